/* File: pkg/dpsram_params.svh */
/*
  Constants for the host controller of one port of a dual-port SRAM
  with eight semaphore latches. Assumes a 200 MHz controller clock
  and a fastest-grade memory port.
*/
// How it works
// - Memory select stays high whenever semaphore select is low.
// - Deassert select or output enable for the update pulse before reading back.
// - Read back after requesting; zero means owned, one means keep polling.
// - Write one to give up a latch or withdraw a request.
// - Write one to every latch during power-up initialisation.
// - Memory read needs output enable and select low, then access time.
// - Write data stands the set-up time before read/write rises.
// - Hosts keep both ports off the same location at once.
// - Read/write stays high whenever the address changes.
`ifndef DPSRAM_PARAMS_SVH
`define DPSRAM_PARAMS_SVH

`define ADDR_WIDTH          12
`define DATA_WIDTH          8
`define LATCH_COUNT         8
`define SYNC_STAGES         2
`define CNT_WIDTH           4

`define CLK_PERIOD_NS       5
`define SELECT_ACCESS_NS    15
`define DRIVE_EN_ACCESS_NS  10
`define WRITE_PULSE_NS      12
`define WRITE_DATA_SETUP_NS 10
`define LATCH_UPDATE_NS     10
`define LATCH_WR_TO_RD_NS   5

`define CEIL_CYC(ns)  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MEM_RD_CYC  (`CEIL_CYC(`SELECT_ACCESS_NS > `DRIVE_EN_ACCESS_NS ? \
                     `SELECT_ACCESS_NS : `DRIVE_EN_ACCESS_NS) + `SYNC_STAGES)
`define LATCH_RD_CYC (`CEIL_CYC(`LATCH_WR_TO_RD_NS + `DRIVE_EN_ACCESS_NS) + `SYNC_STAGES)
`define WR_CYC      (`CEIL_CYC(`WRITE_PULSE_NS > `WRITE_DATA_SETUP_NS ? \
                     `WRITE_PULSE_NS : `WRITE_DATA_SETUP_NS))
`define GAP_CYC     (`CEIL_CYC(`LATCH_UPDATE_NS))

`endif

/* File: pkg/dpsram_pkg.sv */
/*
  Types for the dual-port SRAM port host.
  Assumes dpsram_params.svh is compiled alongside.
*/
`default_nettype none

package dpsram_pkg;

  typedef enum logic [2:0] {
    OP_MEM_READ,
    OP_MEM_WRITE,
    OP_LATCH_ACQUIRE,
    OP_LATCH_RELEASE,
    OP_LATCH_INIT
  } host_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_GAP,
    ST_RD_ACCESS,
    ST_FINISH
  } seq_state_t;

endpackage

`default_nettype wire

/* File: logic/pin_sync.sv */
/*
  Two-flop synchroniser for a bus of pin inputs.
  Assumes each bit is sampled independently; the caller only reads
  data that has been stable for the whole wait.
*/
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* File: logic/port_host.sv */
/*
  Host controller for one port of a dual-port SRAM with semaphores.
  Runs memory reads and writes, semaphore acquire with polling,
  release and power-up initialisation from a simple command port.
  Assumes the memory pins are wired directly and the data bus is
  resolved outside from data_oe_out.
*/
`include "dpsram_params.svh"
`default_nettype none

module port_host (
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  // Command side
  input  wire logic                     cmd_valid_in,
  input  wire dpsram_pkg::host_op_t     cmd_op_in,
  input  wire logic [`ADDR_WIDTH-1:0]   cmd_addr_in,
  input  wire logic [`DATA_WIDTH-1:0]   cmd_wdata_in,
  input  wire logic                     cancel_in,
  output var  logic                     ready_out,
  output var  logic                     done_out,
  output var  logic [`DATA_WIDTH-1:0]   rdata_out,
  output var  logic                     granted_out,
  // Memory port pins
  output var  logic                     mem_select_n_out,
  output var  logic                     latch_select_n_out,
  output var  logic                     out_enable_n_out,
  output var  logic                     rw_n_out,
  output var  logic [`ADDR_WIDTH-1:0]   addr_out,
  output var  logic [`DATA_WIDTH-1:0]   data_out,
  output var  logic                     data_oe_out,
  input  wire logic [`DATA_WIDTH-1:0]   data_in
);
  import dpsram_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  seq_state_t             state_reg, state_next;
  host_op_t               op_reg, op_next;
  logic [`ADDR_WIDTH-1:0] addr_reg, addr_next;
  logic [`DATA_WIDTH-1:0] wdata_reg, wdata_next;
  logic [`CNT_WIDTH-1:0]  cnt_reg;
  logic                   cancel_reg;
  logic [`DATA_WIDTH-1:0] data_sync;
  logic                   is_latch_next;
  logic                   rd_last;

  // ==========================================================
  // Pin input synchroniser
  // ==========================================================
  pin_sync #(
    .WIDTH (`DATA_WIDTH)
  ) u_data_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in (data_in),
    .sync_out (data_sync)
  );

  // ==========================================================
  // Sequencer
  // ==========================================================
  assign is_latch_next = (op_next != OP_MEM_READ) && (op_next != OP_MEM_WRITE);
  // Read waits include the synchroniser so sampled data is settled
  assign rd_last = (op_reg == OP_MEM_READ) ? (cnt_reg == `CNT_WIDTH'(`MEM_RD_CYC - 1))
                                            : (cnt_reg == `CNT_WIDTH'(`LATCH_RD_CYC - 1));

  always_comb
  begin
    state_next = state_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (cmd_valid_in)
        begin
          state_next = ST_SETUP;
          op_next    = cmd_op_in;
          addr_next  = cmd_addr_in;
          wdata_next = cmd_wdata_in;
          if (cmd_op_in == OP_LATCH_INIT)
          begin
            addr_next  = '0;
            wdata_next = 8'hff;
          end
          else if (cmd_op_in == OP_LATCH_ACQUIRE)
            wdata_next = 8'h00;
          else if (cmd_op_in == OP_LATCH_RELEASE)
            wdata_next = 8'hff;
        end
      end
      ST_SETUP:
        state_next = (op_reg == OP_MEM_READ) ? ST_RD_ACCESS : ST_WR_PULSE;
      ST_WR_PULSE:
        if (cnt_reg == `CNT_WIDTH'(`WR_CYC - 1))
          state_next = ST_WR_END;
      ST_WR_END:
      begin
        unique case (op_reg)
          OP_LATCH_ACQUIRE:
            state_next = ST_GAP;
          OP_LATCH_INIT:
          begin
            if (addr_reg[2:0] == 3'h7)
              state_next = ST_FINISH;
            else
            begin
              state_next = ST_SETUP;
              addr_next  = addr_reg + `ADDR_WIDTH'(1);
            end
          end
          default:
            state_next = ST_FINISH;
        endcase
      end
      ST_GAP:
        if (cnt_reg == `CNT_WIDTH'(`GAP_CYC - 1))
          state_next = ST_RD_ACCESS;
      ST_RD_ACCESS:
      begin
        if (rd_last)
        begin
          if (op_reg != OP_LATCH_ACQUIRE || !data_sync[0])
            state_next = ST_FINISH;
          else if (cancel_reg)
          begin
            // Withdraw a pending request by writing one
            state_next = ST_SETUP;
            op_next    = OP_LATCH_RELEASE;
            wdata_next = 8'hff;
          end
          else
            state_next = ST_GAP;
        end
      end
      ST_FINISH:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_MEM_READ;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      cnt_reg <= '0;
    else if (state_next != state_reg)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + `CNT_WIDTH'(1);
  end

  // Set wins over the clear taken in every idle cycle
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      cancel_reg <= 1'b0;
    else if (cancel_in)
      cancel_reg <= 1'b1;
    else if (state_reg == ST_IDLE)
      cancel_reg <= 1'b0;
  end

  // ==========================================================
  // Pin drivers, registered from the next state
  // ==========================================================
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      mem_select_n_out   <= 1'b1;
      latch_select_n_out <= 1'b1;
      out_enable_n_out   <= 1'b1;
      rw_n_out           <= 1'b1;
      addr_out           <= '0;
      data_out           <= '0;
      data_oe_out        <= 1'b0;
    end
    else
    begin
      // Only one select is ever low
      mem_select_n_out   <= !((state_next == ST_WR_PULSE || state_next == ST_RD_ACCESS)
                              && !is_latch_next);
      latch_select_n_out <= !((state_next == ST_WR_PULSE || state_next == ST_RD_ACCESS)
                              && is_latch_next);
      out_enable_n_out   <= (state_next != ST_RD_ACCESS);
      rw_n_out           <= (state_next != ST_WR_PULSE);
      // Address moves only in setup with read/write high; no arbitration
      if (state_next == ST_SETUP)
        addr_out <= addr_next;
      // Data held through the write end for hold time
      data_oe_out <= (state_next == ST_WR_PULSE || state_next == ST_WR_END);
      if (state_next == ST_SETUP)
        data_out <= is_latch_next ? {7'h00, wdata_next[0]} : wdata_next;
    end
  end

  // ==========================================================
  // Command answers
  // ==========================================================
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ready_out   <= 1'b0;
      done_out    <= 1'b0;
      rdata_out   <= '0;
      granted_out <= 1'b0;
    end
    else
    begin
      ready_out <= (state_next == ST_IDLE);
      done_out  <= (state_next == ST_FINISH);
      if (state_reg == ST_IDLE && cmd_valid_in)
        granted_out <= 1'b0;
      else if (state_reg == ST_RD_ACCESS && rd_last)
      begin
        rdata_out <= data_sync;
        if (op_reg == OP_LATCH_ACQUIRE)
          granted_out <= !data_sync[0];
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_one_select;
    !(!mem_select_n_out && !latch_select_n_out);
  endproperty
  a_one_select: assert property (p_one_select) else $error("both selects low");

  property p_addr_quiet;
    $changed(addr_out) |-> rw_n_out && $past(rw_n_out);
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("address moved in write");

  property p_wr_pulse;
    $fell(rw_n_out) |-> (!rw_n_out && data_oe_out)[*3] ##1 rw_n_out;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse length wrong");

  property p_data_setup;
    $rose(rw_n_out) |-> $past(data_oe_out, 2) && $past(data_out, 1) == $past(data_out, 2);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("write data not set up");

  property p_update_gap;
    $rose(rw_n_out) && !$past(latch_select_n_out) |->
      (out_enable_n_out && latch_select_n_out)[*2];
  endproperty
  a_update_gap: assert property (p_update_gap) else $error("no update pulse");

  property p_sem_read_wait;
    $fell(out_enable_n_out) && !latch_select_n_out |->
      (!out_enable_n_out && !latch_select_n_out)[*5] ##1 out_enable_n_out;
  endproperty
  a_sem_read_wait: assert property (p_sem_read_wait) else $error("latch read wait wrong");

  property p_mem_read;
    $fell(out_enable_n_out) && latch_select_n_out |->
      !mem_select_n_out && rw_n_out;
  endproperty
  a_mem_read: assert property (p_mem_read) else $error("memory read without select");

  property p_grant_cause;
    $rose(granted_out) |-> !$past(data_sync[0]) && $past(state_reg) == ST_RD_ACCESS;
  endproperty
  a_grant_cause: assert property (p_grant_cause) else $error("grant without zero");

  property p_release_one;
    $fell(rw_n_out) && !latch_select_n_out &&
      (op_reg == OP_LATCH_RELEASE || op_reg == OP_LATCH_INIT) |-> data_out[0];
  endproperty
  a_release_one: assert property (p_release_one) else $error("release wrote zero");

  c_mem_write: cover property ($rose(done_out) && op_reg == OP_MEM_WRITE);
  c_mem_read:  cover property ($rose(done_out) && op_reg == OP_MEM_READ);
  c_granted:   cover property ($rose(granted_out));
  c_polled:    cover property (state_reg == ST_RD_ACCESS ##1 state_reg == ST_GAP);

endmodule

`default_nettype wire

/* File: testbench/dpsram_model.sv */
/*
  Behavioural dual-port SRAM with eight semaphore latches.
  Left port faces the host under test; right port is driven by the bench.
*/
`include "dpsram_params.svh"
`default_nettype none

module dpsram_model #(
  parameter int ACCESS_NS = 12
) (
  input  wire logic                   l_ce_n_in,
  input  wire logic                   l_latch_n_in,
  input  wire logic                   l_oe_n_in,
  input  wire logic                   l_rw_n_in,
  input  wire logic [`ADDR_WIDTH-1:0] l_addr_in,
  input  wire logic [7:0]             l_data_in,
  output var  logic [7:0]             l_data_out,
  output var  logic                   l_oe_out,
  input  wire logic                   r_ce_n_in,
  input  wire logic                   r_latch_n_in,
  input  wire logic                   r_oe_n_in,
  input  wire logic                   r_rw_n_in,
  input  wire logic [`ADDR_WIDTH-1:0] r_addr_in,
  input  wire logic [7:0]             r_data_in,
  output var  logic [7:0]             r_data_out,
  output var  logic                   r_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Storage
  logic [7:0]             mem [4096];
  logic [1:0]             owner [8];
  logic [1:0]             pend [8];
  logic [7:0]             hold [2];
  wire  logic [1:0]       ce_n = {r_ce_n_in, l_ce_n_in};
  wire  logic [1:0]       latch_n = {r_latch_n_in, l_latch_n_in};
  wire  logic [1:0]       oe_n = {r_oe_n_in, l_oe_n_in};
  wire  logic [1:0]       rw_n = {r_rw_n_in, l_rw_n_in};
  wire  logic [`ADDR_WIDTH-1:0] addr [2];
  wire  logic [7:0]       din [2];
  wire  logic [7:0]       dout [2];
  wire  logic [1:0]       drive;

  assign addr[0] = l_addr_in;
  assign addr[1] = r_addr_in;
  assign din[0] = l_data_in;
  assign din[1] = r_data_in;
  assign l_data_out = dout[0];
  assign r_data_out = dout[1];
  assign l_oe_out = drive[0];
  assign r_oe_out = drive[1];

  // Power-up state is deliberately mixed: hosts must free every latch
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      owner[i] = i[0] ? 2'h1 : 2'h2;
      pend[i] = 2'h0;
    end
  end

  // ==========
  // Latch update: 0 free, 1 left owns, 2 right owns
  // Writes are handled one at a time, so only one requester can win
  task automatic latch_write(input int s, input int i, input logic b);
    if (!b)
    begin
      if (owner[i] == 2'h0)
        owner[i] = 2'(s + 1);
      else if (owner[i] != 2'(s + 1))
        pend[i][s] = 1'h1;
    end
    else
    begin
      pend[i][s] = 1'h0;
      if (owner[i] == 2'(s + 1))
      begin
        owner[i] = pend[i][1-s] ? 2'(2 - s) : 2'h0;
        pend[i][1-s] = 1'h0;
      end
    end
  endtask

  // ==========
  // Per-port access
  for (genvar s = 0; s < 2; s++)
  begin : g_port
    wire logic mw = !ce_n[s] && latch_n[s] && !rw_n[s];
    wire logic sw = ce_n[s] && !latch_n[s] && !rw_n[s];
    wire logic srd = ce_n[s] && !latch_n[s] && rw_n[s] && !oe_n[s];
    wire logic mrd = !ce_n[s] && latch_n[s] && rw_n[s] && !oe_n[s];
    // Data is taken as the write ends
    always @(negedge mw)
      if ($time > 0)
        mem[addr[s]] = din[s];
    always @(negedge sw)
      if ($time > 0)
        latch_write(s, int'(addr[s][2:0]), din[s][0]);
    always @(posedge srd)
      hold[s] = {8{owner[addr[s][2:0]] != 2'(s + 1)}};
    assign #(ACCESS_NS) dout[s] = srd ? hold[s] : mem[addr[s]];
    assign drive[s] = srd || mrd;
  end
endmodule

`default_nettype wire

/* File: testbench/test_port_host.sv */
/*
  Self-checking bench for port_host against a dual-port SRAM model.
  Assumes the bench acts as the host on the model's right port.
*/
`include "dpsram_params.svh"
`default_nettype none

module test_port_host;
  timeunit 1ns;
  timeprecision 100ps;
  import dpsram_pkg::*;

  // ==========
  // Signals
  logic                   clk_in = 1'h0;
  logic                   reset_in = 1'h1;
  logic                   cmd_valid_in = 1'h0;
  host_op_t               cmd_op_in = OP_MEM_READ;
  logic [`ADDR_WIDTH-1:0] cmd_addr_in = 12'h0;
  logic [7:0]             cmd_wdata_in = 8'h0;
  logic                   cancel_in = 1'h0;
  logic                   ready_out, done_out, granted_out, data_oe_out;
  logic                   mem_select_n_out, latch_select_n_out, out_enable_n_out, rw_n_out;
  logic [`ADDR_WIDTH-1:0] addr_out;
  logic [7:0]             rdata_out, data_out, data_in, m_dl, m_dr, q;
  logic [7:0]             last_l = 8'h0;
  logic [7:0]             r_data = 8'h0;
  logic                   m_oe_l, m_oe_r;
  logic                   r_ce_n = 1'h1, r_latch_n = 1'h1, r_oe_n = 1'h1, r_rw_n = 1'h1;
  logic [`ADDR_WIDTH-1:0] r_addr = 12'h0;
  int                     failures = 0;
  int                     tests_run = 0;

  always #2.5 clk_in = ~clk_in;

  // Released bus shows the inverse of its last value, never a stale match
  always @*
    if (data_oe_out === 1'h1)
      last_l = data_out;
    else if (m_oe_l === 1'h1)
      last_l = m_dl;
  assign data_in = data_oe_out ? data_out : m_oe_l ? m_dl : ~last_l;

  port_host u_dut (
    .clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
    .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in), .cancel_in(cancel_in),
    .ready_out(ready_out), .done_out(done_out), .rdata_out(rdata_out),
    .granted_out(granted_out), .mem_select_n_out(mem_select_n_out),
    .latch_select_n_out(latch_select_n_out), .out_enable_n_out(out_enable_n_out),
    .rw_n_out(rw_n_out), .addr_out(addr_out), .data_out(data_out),
    .data_oe_out(data_oe_out), .data_in(data_in)
  );

  dpsram_model u_model (
    .l_ce_n_in(mem_select_n_out), .l_latch_n_in(latch_select_n_out),
    .l_oe_n_in(out_enable_n_out), .l_rw_n_in(rw_n_out), .l_addr_in(addr_out),
    .l_data_in(data_in), .l_data_out(m_dl), .l_oe_out(m_oe_l),
    .r_ce_n_in(r_ce_n), .r_latch_n_in(r_latch_n), .r_oe_n_in(r_oe_n), .r_rw_n_in(r_rw_n),
    .r_addr_in(r_addr), .r_data_in(r_data), .r_data_out(m_dr), .r_oe_out(m_oe_r)
  );

  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic run_cmd(input host_op_t op, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_in);
    while (ready_out !== 1'h1)
      @(negedge clk_in);
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_wdata_in = d;
    cmd_valid_in = 1'h1;
    @(negedge clk_in);
    cmd_valid_in = 1'h0;
    while (done_out !== 1'h1 && n < 400)
    begin
      @(negedge clk_in);
      n++;
    end
    check("command done", {7'h0, done_out}, 8'h01);
  endtask

  // Right host: select high while latch select low, data before write edge
  task automatic r_write(input logic s, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_in);
    r_addr = a;
    r_data = d;
    @(negedge clk_in);
    r_ce_n = s;
    r_latch_n = !s;
    r_rw_n = 1'h0;
    repeat (3) @(negedge clk_in);
    r_rw_n = 1'h1;
    @(negedge clk_in);
    r_ce_n = 1'h1;
    r_latch_n = 1'h1;
    r_data = ~d;
    repeat (2) @(negedge clk_in);
  endtask

  task automatic r_read(input logic s, input logic [11:0] a);
    @(negedge clk_in);
    r_addr = a;
    @(negedge clk_in);
    r_ce_n = s;
    r_latch_n = !s;
    r_oe_n = 1'h0;
    repeat (4) @(negedge clk_in);
    q = m_dr;
    r_oe_n = 1'h1;
    r_ce_n = 1'h1;
    r_latch_n = 1'h1;
    repeat (2) @(negedge clk_in);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset;
    @(negedge clk_in);
    check("ready", {7'h0, ready_out}, 8'h01);
    check("idle pins", {4'h0, mem_select_n_out, latch_select_n_out, out_enable_n_out,
          data_oe_out}, 8'h0e);
    $display("reset test done");
  endtask

  task automatic t_init;
    for (int i = 0; i < 8; i++)
      r_write(1'h1, 12'(i), 8'hff);
    run_cmd(OP_LATCH_INIT, 12'h0, 8'h0);
    for (int i = 0; i < 8; i++)
    begin
      r_read(1'h1, 12'(i));
      check("latch free", q, 8'hff);
    end
    $display("init test done");
  endtask

  // Ports take turns on each word, never overlapping
  task automatic t_memory;
    logic [11:0] a [3];
    logic [7:0]  d;
    a = '{12'h000, 12'hfff, 12'h9a5};
    for (int i = 0; i < 3; i++)
    begin
      d = a[i][7:0] ^ 8'h3c;
      run_cmd(OP_MEM_WRITE, a[i], d);
      r_read(1'h0, a[i]);
      check("far read", q, d);
      r_write(1'h0, a[i], ~d);
      run_cmd(OP_MEM_READ, a[i], 8'h0);
      check("host read", rdata_out, ~d);
    end
    $display("memory test done");
  endtask

  task automatic t_acquire;
    run_cmd(OP_LATCH_ACQUIRE, 12'hffb, 8'h0);
    check("granted", {7'h0, granted_out}, 8'h01);
    check("latch read", rdata_out, 8'h00);
    r_read(1'h1, 12'h3);
    check("far sees owned", q, 8'hff);
    r_write(1'h1, 12'h3, 8'hfe);
    r_read(1'h1, 12'h3);
    check("denied", q, 8'hff);
    run_cmd(OP_LATCH_RELEASE, 12'h3, 8'h0);
    r_read(1'h1, 12'h3);
    check("handover", q, 8'h00);
    fork
      run_cmd(OP_LATCH_ACQUIRE, 12'h3, 8'h0);
      begin
        repeat (40) @(negedge clk_in);
        check("polling", {7'h0, granted_out}, 8'h00);
        r_write(1'h1, 12'h3, 8'h01);
      end
    join
    check("granted after poll", {7'h0, granted_out}, 8'h01);
    run_cmd(OP_LATCH_RELEASE, 12'h3, 8'h0);
    $display("acquire test done");
  endtask

  task automatic t_cancel;
    r_write(1'h1, 12'h5, 8'hfe);
    fork
      run_cmd(OP_LATCH_ACQUIRE, 12'h5, 8'h0);
      begin
        repeat (30) @(negedge clk_in);
        cancel_in = 1'h1;
        @(negedge clk_in);
        cancel_in = 1'h0;
      end
    join
    check("cancel granted", {7'h0, granted_out}, 8'h00);
    check("cancel rdata", rdata_out, 8'hff);
    r_write(1'h1, 12'h5, 8'h01);
    r_write(1'h1, 12'h5, 8'hfe);
    r_read(1'h1, 12'h5);
    check("request withdrawn", q, 8'h00);
    $display("cancel test done");
  endtask

  // ==========
  // Main sequence and watchdog
  initial
  begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'h0;
    t_reset;
    t_init;
    t_memory;
    t_acquire;
    t_cancel;
    end_sim;
  end

  // Tests need under a thousand cycles; allow twenty times that
  initial
  begin
    #100000;
    failures++;
    end_sim;
  end
endmodule

`default_nettype wire
